// >>> uart_line_model.sv
`timescale 1ns/1ps
`default_nettype none

// far-side serialiser: takes characters and records the line chosen
module uart_line_model
   import uart_shadow_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // character stream from the block
   input wire logic tx_valid,
   input wire tx_char_t tx_char,
   output logic tx_ready,
   // bench control: a stalled line backs the queues up
   input wire logic stall
);
   logic [8:0] got[$];

   // ready only out of reset and while the line is not stalled
   assign tx_ready = rst_b && !stall;

   // one character per handshake, kept with its line flag
   always @(posedge clk) begin
      if (rst_b && tx_valid && tx_ready) begin
         got.push_back(tx_char);
      end
   end
endmodule

`default_nettype wire

// >>> uart_shadow_cfg.svh
`ifndef UART_SHADOW_CFG_SVH
`define UART_SHADOW_CFG_SVH

// shadow slots: slot 10 sits at its fixed address, the rest around it
`define SHADOW_SLOT10_ADDR 32'h50001158
`define SHADOW_SLOT10_INDEX 32'h0000000a
`define SHADOW_SLOT_COUNT 32'h00000010
`define SHADOW_BASE_ADDR (`SHADOW_SLOT10_ADDR - (`SHADOW_SLOT10_INDEX << 2))
`define SHADOW_END_ADDR (`SHADOW_BASE_ADDR + (`SHADOW_SLOT_COUNT << 2))
`define SHADOW_RESET 32'h00000000
`define BYTE_RESET 8'h00

// control and status words placed just past the slots
`define CTRL_ADDR (`SHADOW_BASE_ADDR + 32'h00000040)
`define STATUS_ADDR (`SHADOW_BASE_ADDR + 32'h00000044)
`define CTRL_RESET 2'h0

// field positions
`define BYTE_MSB 7
`define CTRL_FIFO_EN_BIT 0
`define CTRL_IR_MODE_BIT 1
`define STAT_DR_BIT 0
`define STAT_OVR_BIT 1
`define STAT_TXLOST_BIT 2
`define STAT_TX_HOLDING_EMPTY_BIT 5
`define STAT_TXFULL_BIT 6

// fifo depth defaults
`define RX_DEPTH_DEFAULT 16
`define TX_DEPTH_DEFAULT 16

`endif

// >>> uart_shadow_pkg.sv
`default_nettype none

package uart_shadow_pkg;

   // one register-port request, all strobes one cycle long
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // one received character from a deserialiser
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rx_char_t;

   // one character to transmit and the line it goes out on
   typedef struct packed {
      logic ir;
      logic [7:0] data;
   } tx_char_t;

endpackage

`default_nettype wire

// >>> uart_shadow_port.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uart_shadow_cfg.svh"

module uart_shadow_port
   import uart_shadow_pkg::*;
#(
   parameter int RX_DEPTH = `RX_DEPTH_DEFAULT,
   parameter int TX_DEPTH = `TX_DEPTH_DEFAULT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire bus_req_t bus_req,
   output logic [31:0] rdata,
   // received characters from the two deserialisers
   input wire rx_char_t uart_rx,
   input wire rx_char_t ir_rx,
   // characters toward the serialisers
   output logic tx_valid,
   output tx_char_t tx_char,
   input wire logic tx_ready,
   // line status seen by the rest of the uart
   output logic rx_data_ready,
   output logic tx_holding_empty,
   output logic overrun
);

   localparam int RCW = $clog2(RX_DEPTH + 1);
   localparam int RPW = $clog2(RX_DEPTH);
   localparam int TCW = $clog2(TX_DEPTH + 1);
   localparam int TPW = $clog2(TX_DEPTH);

   // pointers wrap for free only on powers of two
   if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_rx
      $error("uart_shadow_port: RX_DEPTH must be a power of two >= 2");
   end
   if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_bad_tx
      $error("uart_shadow_port: TX_DEPTH must be a power of two >= 2");
   end

   // address decode
   logic slot_hit;
   logic wr_slot;
   logic rd_slot;
   logic wr_ctrl;
   logic rd_ctrl;
   logic rd_stat;

   // any of the sixteen aligned words reaches the same byte path
   assign slot_hit = (bus_req.addr >= `SHADOW_BASE_ADDR) &&
                     (bus_req.addr < `SHADOW_END_ADDR) &&
                     (bus_req.addr[1:0] == 2'h0);
   assign wr_slot = bus_req.wr & slot_hit;
   assign rd_slot = bus_req.rd & slot_hit;
   assign wr_ctrl = bus_req.wr & (bus_req.addr == `CTRL_ADDR);
   assign rd_ctrl = bus_req.rd & (bus_req.addr == `CTRL_ADDR);
   assign rd_stat = bus_req.rd & (bus_req.addr == `STATUS_ADDR);

   // control word: fifo enable and infrared mode
   logic [1:0] ctrl_q;
   logic fifo_en;
   logic ir_mode;
   logic flush;

   assign fifo_en = ctrl_q[`CTRL_FIFO_EN_BIT];
   assign ir_mode = ctrl_q[`CTRL_IR_MODE_BIT];
   // switching fifo mode empties both queues so no stale mix remains
   assign flush = wr_ctrl &
                  (bus_req.wdata[`CTRL_FIFO_EN_BIT] != fifo_en);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= bus_req.wdata[1:0];
      end
   end

   // receive queue
   logic [7:0] rx_mem [RX_DEPTH];
   logic [RPW-1:0] rx_rd_q;
   logic [RPW-1:0] rx_wr_q;
   logic [RCW-1:0] rx_cnt_q;
   logic [RCW-1:0] rx_cnt_d;
   logic rx_in_valid;
   logic [7:0] rx_in_byte;
   logic rx_full;
   logic rx_pop;
   logic rx_push;
   logic rx_ovw;
   logic rx_drop;
   logic [7:0] rx_head;

   // the active line's deserialiser feeds the queue
   assign rx_in_valid = ir_mode ? ir_rx.valid : uart_rx.valid;
   assign rx_in_byte = ir_mode ? ir_rx.data : uart_rx.data;
   // without fifos the queue is one character deep
   assign rx_full = fifo_en ? (rx_cnt_q == RCW'(RX_DEPTH)) :
                              (rx_cnt_q != '0);
   assign rx_pop = rd_slot & (rx_cnt_q != '0) & !flush;
   assign rx_push = rx_in_valid & (!rx_full | rx_pop) & !flush;
   assign rx_ovw = rx_in_valid & !fifo_en & rx_full & !rx_pop &
                   !flush;
   assign rx_drop = rx_in_valid & fifo_en & rx_full & !rx_pop &
                    !flush;
   assign rx_head = rx_mem[rx_rd_q];
   assign rx_cnt_d = flush ? '0 :
                     RCW'(rx_cnt_q + RCW'(rx_push) - RCW'(rx_pop));

   // one write port per entry: push at the tail, overwrite at the head
   // entries clear on reset so an early slot read shows the reset value
   for (genvar i = 0; i < RX_DEPTH; i++) begin : g_rx_mem
      logic we;
      assign we = (rx_push && rx_wr_q == RPW'(i)) ||
                  (rx_ovw && rx_rd_q == RPW'(i));
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            rx_mem[i] <= `BYTE_RESET;
         end else if (we) begin
            rx_mem[i] <= rx_in_byte;
         end
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (!rst_b || flush) begin
         rx_rd_q <= '0;
         rx_wr_q <= '0;
         rx_cnt_q <= '0;
      end else begin
         rx_rd_q <= rx_rd_q + RPW'(rx_pop);
         rx_wr_q <= rx_wr_q + RPW'(rx_push);
         rx_cnt_q <= rx_cnt_d;
      end
   end

   // data ready follows the fill level; a new byte beats a read-clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rx_data_ready <= 1'b0;
         overrun <= 1'b0;
      end else begin
         rx_data_ready <= (rx_cnt_d != '0);
         overrun <= rx_ovw | rx_drop | (overrun & !rd_stat);
      end
   end

   // transmit queue
   logic [7:0] tx_mem [TX_DEPTH];
   logic [TPW-1:0] tx_rd_q;
   logic [TPW-1:0] tx_wr_q;
   logic [TCW-1:0] tx_cnt_q;
   logic [TCW-1:0] tx_cnt_d;
   logic tx_full;
   logic tx_pop;
   logic tx_push;
   logic tx_ovw;
   logic tx_drop;
   logic tx_lost_q;
   logic buf_ready;
   tx_char_t buf_char;

   // only the low byte ever enters the queue
   assign tx_full = fifo_en ? (tx_cnt_q == TCW'(TX_DEPTH)) :
                              (tx_cnt_q != '0);
   assign tx_pop = (tx_cnt_q != '0) & buf_ready & !flush;
   assign tx_push = wr_slot & (!tx_full | tx_pop) & !flush;
   assign tx_ovw = wr_slot & !fifo_en & tx_full & !tx_pop &
                   !flush;
   assign tx_drop = wr_slot & fifo_en & tx_full & !tx_pop &
                    !flush;
   assign tx_cnt_d = flush ? '0 :
                     TCW'(tx_cnt_q + TCW'(tx_push) - TCW'(tx_pop));
   // route is taken when the byte leaves, so a mode switch applies
   assign buf_char = '{ir: ir_mode, data: tx_mem[tx_rd_q]};

   // per-entry write: append, or replace the pending byte
   for (genvar i = 0; i < TX_DEPTH; i++) begin : g_tx_mem
      logic we;
      assign we = (tx_push && tx_wr_q == TPW'(i)) ||
                  (tx_ovw && tx_rd_q == TPW'(i));
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            tx_mem[i] <= `BYTE_RESET;
         end else if (we) begin
            tx_mem[i] <= bus_req.wdata[`BYTE_MSB:0];
         end
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (!rst_b || flush) begin
         tx_rd_q <= '0;
         tx_wr_q <= '0;
         tx_cnt_q <= '0;
      end else begin
         tx_rd_q <= tx_rd_q + TPW'(tx_pop);
         tx_wr_q <= tx_wr_q + TPW'(tx_push);
         tx_cnt_q <= tx_cnt_d;
      end
   end

   // holding empty drops on the write that fills it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tx_holding_empty <= 1'b1;
         tx_lost_q <= 1'b0;
      end else begin
         tx_holding_empty <= (tx_cnt_d == '0);
         tx_lost_q <= tx_drop | (tx_lost_q & !rd_stat);
      end
   end

   // buffer absorbs a serialiser stall without losing a byte
   uart_skid_buf #(
      .W($bits(tx_char_t))
   ) u_tx_buf (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(tx_pop),
      .in_data(buf_char),
      .in_ready(buf_ready),
      .out_valid(tx_valid),
      .out_data(tx_char),
      .out_ready(tx_ready)
   );

   // read data, one cycle after the strobe
   logic [31:0] status_word;
   logic [31:0] rdata_d;

   assign status_word = (32'(rx_data_ready) << `STAT_DR_BIT) |
                        (32'(overrun) << `STAT_OVR_BIT) |
                        (32'(tx_lost_q) << `STAT_TXLOST_BIT) |
                        (32'(tx_holding_empty) << `STAT_TX_HOLDING_EMPTY_BIT) |
                        (32'(tx_full) << `STAT_TXFULL_BIT);
   // stale head bytes are returned as is; data ready says if valid
   assign rdata_d = rd_slot ? {24'h000000, rx_head} :
                    rd_ctrl ? {30'h00000000, ctrl_q} :
                    rd_stat ? status_word : `SHADOW_RESET;

   // unmapped reads and idle cycles return zero
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata <= `SHADOW_RESET;
      end else begin
         rdata <= rdata_d;
      end
   end

   // checks
   AST_SLOT_UPPER_ZERO: assert property (
      @(posedge clk) disable iff (!rst_b)
      rd_slot |=> rdata[31:8] == 24'h000000)
      else $error("slot read returned nonzero upper bits");

   AST_SLOT_HEAD: assert property (
      @(posedge clk) disable iff (!rst_b)
      rd_slot && rx_cnt_q != '0 |=> rdata[7:0] == $past(rx_head))
      else $error("slot read did not return queue head");

   AST_DR_LEVEL: assert property (
      @(posedge clk) disable iff (!rst_b)
      rx_data_ready == (rx_cnt_q != '0))
      else $error("data ready disagrees with receive level");

   AST_RX_OVERWRITE: assert property (
      @(posedge clk) disable iff (!rst_b)
      rx_ovw |=> overrun && rx_cnt_q == RCW'(1) &&
                 rx_head == $past(rx_in_byte))
      else $error("unfifoed overrun did not overwrite and flag");

   AST_RX_DROP: assert property (
      @(posedge clk) disable iff (!rst_b)
      rx_drop |=> overrun && $stable(rx_cnt_q) && $stable(rx_wr_q))
      else $error("full receive fifo did not keep contents");

   AST_TX_HOLDING_EMPTY_CLEAR: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_slot && !fifo_en && tx_holding_empty |=> !tx_holding_empty)
      else $error("write left holding empty set");

   AST_TX_REPLACE: assert property (
      @(posedge clk) disable iff (!rst_b)
      tx_ovw |=> tx_cnt_q == TCW'(1) &&
                 tx_mem[tx_rd_q] == $past(bus_req.wdata[7:0]))
      else $error("pending byte not replaced by later write");

   AST_TX_BOUND: assert property (
      @(posedge clk) disable iff (!rst_b)
      fifo_en && tx_cnt_q != TCW'(TX_DEPTH) && wr_slot && !flush
      |=> tx_cnt_q != '0 && !tx_holding_empty)
      else $error("write below depth not accepted");

   AST_TX_DISCARD: assert property (
      @(posedge clk) disable iff (!rst_b)
      tx_drop |=> $stable(tx_cnt_q) && $stable(tx_wr_q) && tx_lost_q)
      else $error("write to full transmit fifo changed it");

   AST_TX_ROUTE: assert property (
      @(posedge clk) disable iff (!rst_b)
      tx_pop && buf_ready && !tx_valid
      |=> tx_valid && tx_char.ir == $past(ir_mode))
      else $error("transmitted byte went to wrong line");

   AST_SLOT_MIRROR: assert property (
      @(posedge clk) disable iff (!rst_b)
      rd_slot |=> rdata[7:0] == $past(rx_head))
      else $error("slot read did not mirror receive head");

   AST_RX_IDLE_LINE: assert property (
      @(posedge clk) disable iff (!rst_b)
      (ir_mode ? !ir_rx.valid : !uart_rx.valid) && !flush
      |=> rx_wr_q == $past(rx_wr_q))
      else $error("byte entered queue without active line valid");

   AST_RX_ACCEPT: assert property (
      @(posedge clk) disable iff (!rst_b)
      fifo_en && !rx_full && rx_in_valid && !flush
      |=> rx_cnt_q != '0 && rx_data_ready)
      else $error("receive fifo refused a byte below depth");

   AST_OVR_STICKY: assert property (
      @(posedge clk) disable iff (!rst_b)
      overrun && !rd_stat |=> overrun)
      else $error("overrun cleared without status read");

   AST_TX_HOLDING_EMPTY_LEVEL: assert property (
      @(posedge clk) disable iff (!rst_b)
      tx_holding_empty == (tx_cnt_q == '0))
      else $error("holding empty disagrees with transmit level");

   AST_WR_LOW_BYTE: assert property (
      @(posedge clk) disable iff (!rst_b)
      tx_push |=> tx_mem[$past(tx_wr_q)] == $past(bus_req.wdata[7:0]))
      else $error("queued byte differs from written low byte");

endmodule

`default_nettype wire

// >>> uart_shadow_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_shadow_cfg.svh"

module uart_shadow_port_tb;
   import uart_shadow_pkg::*;
   // small depths keep fill and overflow runs short
   localparam int RXD = 4;
   localparam int TXD = 4;
   localparam logic [31:0] SLOT10 = `SHADOW_SLOT10_ADDR;
   localparam logic [31:0] BASE = `SHADOW_BASE_ADDR;
   localparam logic [31:0] CTRL = `CTRL_ADDR;
   localparam logic [31:0] STAT = `STATUS_ADDR;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic stall = 1'b0;
   bus_req_t bus_req = '0;
   rx_char_t uart_rx = '0;
   rx_char_t ir_rx = '0;
   logic [31:0] rdata;
   logic tx_valid, tx_ready, rx_data_ready, tx_holding_empty, overrun;
   tx_char_t tx_char;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;

   uart_shadow_port #(.RX_DEPTH(RXD), .TX_DEPTH(TXD)) uut (
      .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
      .uart_rx(uart_rx), .ir_rx(ir_rx), .tx_valid(tx_valid),
      .tx_char(tx_char), .tx_ready(tx_ready),
      .rx_data_ready(rx_data_ready), .tx_holding_empty(tx_holding_empty),
      .overrun(overrun));

   uart_line_model line (
      .clk(clk), .rst_b(rst_b), .tx_valid(tx_valid), .tx_char(tx_char),
      .tx_ready(tx_ready), .stall(stall));

   always #10 clk = ~clk;

   // hang guard, well above the under 150 cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one strobe cycle; read data is sampled just after the taking edge
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b0;
      #1;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp,
                         input logic [31:0] mask);
      bus(1'b0, a, 32'h0);
      chk(rdata & mask, exp);
   endtask

   // one-cycle character pulse from a deserialiser
   task automatic send_rx(input logic ir, input logic [7:0] d);
      @(posedge clk);
      if (ir) begin
         ir_rx <= '{valid: 1'b1, data: d};
      end else begin
         uart_rx <= '{valid: 1'b1, data: d};
      end
      @(posedge clk);
      ir_rx.valid <= 1'b0;
      uart_rx.valid <= 1'b0;
      #1;
   endtask

   task automatic t_reset();
      chk({29'h0, rx_data_ready, tx_holding_empty, overrun}, 32'h2);
      rd_chk(SLOT10, 32'h0, 32'hffffffff);
      rd_chk(32'h50001180, 32'h0, 32'hffffffff);
   endtask

   task automatic t_rx_nofifo();
      send_rx(1'b0, 8'ha5);
      chk({31'h0, rx_data_ready}, 32'h1);
      rd_chk(BASE, 32'ha5, 32'hffffffff);
      chk({31'h0, rx_data_ready}, 32'h0);
      send_rx(1'b0, 8'h11);
      send_rx(1'b0, 8'h22);
      chk({31'h0, overrun}, 32'h1);
      rd_chk(BASE + 32'h3c, 32'h22, 32'hffffffff);
      rd_chk(STAT, 32'h22, 32'h23);
      chk({31'h0, overrun}, 32'h0);
   endtask

   // infrared mode: only the infrared input fills, bytes leave flagged
   task automatic t_ir();
      bus(1'b1, CTRL, 32'h2);
      rd_chk(CTRL, 32'h2, 32'hffffffff);
      line.got.delete();
      send_rx(1'b1, 8'h3c);
      send_rx(1'b0, 8'h77);
      rd_chk(SLOT10, 32'h3c, 32'hffffffff);
      chk({31'h0, rx_data_ready}, 32'h0);
      bus(1'b1, SLOT10, 32'h0000125a);
      repeat (6) @(posedge clk);
      chk(32'(line.got.size()), 32'h1);
      chk({23'h0, line.got[0]}, 32'h15a);
   endtask

   task automatic t_rx_fifo();
      bus(1'b1, CTRL, 32'h1);
      for (int i = 0; i < RXD + 1; i++) begin
         send_rx(1'b0, 8'h60 + 8'(i));
      end
      chk({31'h0, overrun}, 32'h1);
      for (int i = 0; i < RXD; i++) begin
         rd_chk(SLOT10, 32'h60 + 32'(i), 32'hffffffff);
      end
      chk({31'h0, rx_data_ready}, 32'h0);
      rd_chk(STAT, 32'h2, 32'h2);
   endtask

   // stalled line: two bytes sit in the buffer, a third waits and is
   // replaced by a fourth written before holding-empty returns
   task automatic t_tx_nofifo();
      bus(1'b1, CTRL, 32'h0);
      line.got.delete();
      stall <= 1'b1;
      bus(1'b1, SLOT10, 32'hffffff41);
      chk({31'h0, tx_holding_empty}, 32'h0);
      repeat (3) @(posedge clk);
      bus(1'b1, SLOT10, 32'h00000042);
      repeat (3) @(posedge clk);
      bus(1'b1, SLOT10, 32'h00000043);
      bus(1'b1, SLOT10, 32'h0000ab44);
      repeat (3) @(posedge clk);
      stall <= 1'b0;
      repeat (10) @(posedge clk);
      chk(32'(line.got.size()), 32'h3);
      chk({23'h0, line.got[0]}, 32'h41);
      chk({23'h0, line.got[1]}, 32'h42);
      chk({23'h0, line.got[2]}, 32'h44);
      chk({31'h0, tx_holding_empty}, 32'h1);
   endtask

   // queue depth plus two buffer places accepted, the next write lost
   task automatic t_tx_fifo();
      bus(1'b1, CTRL, 32'h1);
      line.got.delete();
      stall <= 1'b1;
      for (int i = 0; i < TXD + 3; i++) begin
         bus(1'b1, SLOT10, 32'h80 + 32'(i));
      end
      rd_chk(STAT, 32'h44, 32'h64);
      stall <= 1'b0;
      repeat (20) @(posedge clk);
      chk(32'(line.got.size()), 32'(TXD + 2));
      rd_chk(STAT, 32'h20, 32'h64);
      for (int i = 0; i < TXD + 2; i++) begin
         chk({23'h0, line.got[i]}, 32'h80 + 32'(i));
      end
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_rx_nofifo();
      t_ir();
      t_rx_fifo();
      t_tx_nofifo();
      t_tx_fifo();
      print_verdict();
   end
endmodule

`default_nettype wire

// >>> uart_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer; outputs and in_ready come straight from flops
module uart_skid_buf #(
   parameter int W = 9
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // filling side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // draining side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);

   if (W < 1) begin : g_bad_width
      $error("uart_skid_buf: W must be at least 1");
   end

   logic [W-1:0] e1_q;
   logic v1_q;
   logic push;
   logic pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // head entry refills from the spare entry first to keep order
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
         v1_q <= 1'b0;
      end else begin
         out_valid <= pop ? (v1_q | push) : (out_valid | push);
         v1_q <= pop ? (v1_q & push) : (v1_q | (push & out_valid));
      end
   end

   // data moves without reset; valid flags qualify it
   always_ff @(posedge clk) begin
      if (pop) begin
         out_data <= v1_q ? e1_q : in_data;
      end else if (push && !out_valid) begin
         out_data <= in_data;
      end
      if (push && ((pop && v1_q) || (!pop && out_valid))) begin
         e1_q <= in_data;
      end
   end

   // ready is low in reset and when both entries hold a word
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         in_ready <= 1'b0;
      end else begin
         in_ready <= !(pop ? (v1_q & push) : (v1_q | (push & out_valid)));
      end
   end

   // a stalled word holds still until taken
   AST_SKID_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("buffer head changed while stalled");

endmodule

`default_nettype wire
